// *** reset_gen_pkg.sv ***
// constants, field layout and carrier types for the reset signal generator
// assumes a single 250 MHz system clock and an avalon-mm register slave
package reset_gen_pkg;
  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int STRETCH_MS     = 1;
  localparam int STRETCH_CYCLES = STRETCH_MS * CLK_MHZ * 1000;
  localparam int GLITCH_NS      = 100;
  localparam int GLITCH_CYCLES  = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_W         = $clog2(GLITCH_CYCLES + 1);
  localparam int WDT_CNT_W      = 16;
  // ---------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam int          ADDR_W     = 5;
  localparam logic [4:0]  OFS_CTRL   = 5'h00;
  localparam logic [4:0]  OFS_STATUS = 5'h04;
  localparam logic [4:0]  OFS_MASK   = 5'h08;
  localparam logic [4:0]  OFS_WDTCNT = 5'h0C;
  localparam logic [4:0]  OFS_RSTEN  = 5'h10;
  localparam logic [4:0]  OFS_LEVELS = 5'h14;
  // control fields
  localparam int CTRL_SOFT_BIT = 0;
  localparam int CTRL_PINV_BIT = 1;
  localparam int CTRL_HSEL_BIT = 2;
  localparam logic PINV_RST    = 1'h0;
  localparam logic HSEL_RST    = 1'h0;
  // status / mask fields
  localparam int ST_WDT  = 0;
  localparam int ST_EXT  = 1;
  localparam int ST_CORE = 2;
  localparam int ST_SOFT = 3;
  localparam int ST_W    = 4;
  localparam logic [ST_W-1:0] MASK_RST = 4'h0;
  // ---------------------------------------------------------------------
  // pin inputs that pass the three-stage filter
  // ---------------------------------------------------------------------
  localparam int PIN_MAIN = 0;
  localparam int PIN_EXT  = 1;
  localparam int PIN_PG   = 2;
  localparam int PIN_LPC  = 3;
  localparam int PIN_LINK = 4;
  localparam int PIN_BATT = 5;
  localparam int NPIN     = 6;
  // pins start in their reset-asserting level except battery low: main reset high, rest low
  localparam logic [NPIN-1:0] PIN_INIT = 6'h01;

  typedef enum logic {HOST_SEL_LPC, HOST_SEL_ESPI} host_sel_t;

  typedef struct packed {
    logic batt;
    logic link;
    logic host_if;
    logic host_pwr;
    logic proc;
    logic main_pwr;
    logic keep_wdt;
    logic sys;
  } reset_bus_t;
endpackage

// *** reset_signal_generator.sv ***
// reset signal generator: derives every internal reset from its sources
// assumes pins are asynchronous to clk_sys_i; watchdog, core request and
// the espi platform reset come from logic on clk_sys_i
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps

// Contract
// - system reset from main power, pin, watchdog, soft bit, core request
// - writing the software reset bit forces a system reset
// - host power reset on system reset, power-good low or invert bit set
// - power ok output is the inverse of host power reset
// - host interface reset on system reset, power-good low or invert bit
// - selected lpc or espi platform reset also drives host interface reset
// - serial link reset comes only from its reset pin
// - watchdog resets via system reset, sparing the watchdog event counter
// - watchdog-caused resets skip the glitch-protection hold
// - watchdog event sets the watchdog status bit
// - keep-watchdog reset only from main power or pin; clears counter
// - processor reset rises with system reset, holds 1ms after release
// - block sleep reset when sleep, enable set and clock not requested
// - battery reset pulses at power rise if battery low, else never
// - main power reset clears registers that system reset spares
module reset_signal_generator
  import reset_gen_pkg::*;
#(
  parameter int NBLK           = 8,
  parameter int STRETCH_CYCLES = reset_gen_pkg::STRETCH_CYCLES
) (
  input  wire logic                         clk_sys_i,
  input  wire logic                         srst_i,
  input  wire logic [reset_gen_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [31:0]                  avs_writedata_i,
  input  wire logic [3:0]                   avs_byteenable_i,
  output logic      [31:0]                  avs_readdata_o,
  output logic                              avs_waitrequest_o,
  input  wire logic                         main_power_reset_i,
  input  wire logic                         external_reset_pin_n_i,
  input  wire logic                         host_power_good_i,
  input  wire logic                         lpc_reset_n_i,
  input  wire logic                         serial_link_reset_n_i,
  input  wire logic                         battery_low_i,
  input  wire logic                         watchdog_event_i,
  input  wire logic                         core_reset_request_i,
  input  wire logic                         espi_platform_reset_n_i,
  input  wire logic [NBLK-1:0]              sleep_request_i,
  input  wire logic [NBLK-1:0]              clock_request_i,
  output reset_gen_pkg::reset_bus_t         resets_o,
  output logic                              power_ok_o,
  output logic      [NBLK-1:0]              sleep_reset_o,
  output logic                              irq_o
);
  import reset_gen_pkg::*;

  localparam int CNT_W = $clog2(STRETCH_CYCLES + 1);

  // ---------------------------------------------------------------------
  // pin filter: a change counts once stages two and three agree
  // ---------------------------------------------------------------------
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_next;

  assign pin_raw[PIN_MAIN] = main_power_reset_i;
  assign pin_raw[PIN_EXT]  = external_reset_pin_n_i;
  assign pin_raw[PIN_PG]   = host_power_good_i;
  assign pin_raw[PIN_LPC]  = lpc_reset_n_i;
  assign pin_raw[PIN_LINK] = serial_link_reset_n_i;
  assign pin_raw[PIN_BATT] = battery_low_i;

  always_comb begin
    filt_next = ((sync2_reg ~^ sync3_reg) & sync3_reg) |
                ((sync2_reg ^ sync3_reg) & filt_reg);
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sync1_reg <= PIN_INIT;
      sync2_reg <= PIN_INIT;
      sync3_reg <= PIN_INIT;
      filt_reg  <= PIN_INIT;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= filt_next;
    end
  end

  logic mpr, ext_rst, pg_ok;
  assign mpr     = filt_reg[PIN_MAIN];
  assign ext_rst = ~filt_reg[PIN_EXT];
  assign pg_ok   = filt_reg[PIN_PG];

  // ---------------------------------------------------------------------
  // avalon-mm slave: one wait state, read data latched on first cycle
  // ---------------------------------------------------------------------
  logic            ack_reg, ack_next;
  logic [31:0]     rdata_reg, rdata_next;
  logic            wr_acc, rd_acc;
  logic [31:0]     wmask;
  logic            soft_reg, soft_next, pinv_reg, pinv_next;
  host_sel_t       hsel_reg, hsel_next;
  logic [ST_W-1:0] status_reg, status_next, status_set, mask_reg, mask_next;
  logic [WDT_CNT_W-1:0] wdt_cnt_reg, wdt_cnt_next;
  logic [NBLK-1:0] rsten_reg, rsten_next;
  logic            irq_reg, irq_next;
  reset_bus_t      rst_reg, rst_next;

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign wr_acc = avs_write_i & ack_reg;
  assign rd_acc = avs_read_i & ack_reg;

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{avs_byteenable_i[b]}};
  end

  always_comb begin
    ack_next   = (avs_read_i | avs_write_i) & ~ack_reg;
    rdata_next = rdata_reg;
    if (avs_read_i && !ack_reg) begin
      case (avs_address_i)
        OFS_CTRL:   rdata_next = {29'h0, hsel_reg == HOST_SEL_ESPI,
                                  pinv_reg, soft_reg};
        OFS_STATUS: rdata_next = 32'(status_reg);
        OFS_MASK:   rdata_next = 32'(mask_reg);
        OFS_WDTCNT: rdata_next = 32'(wdt_cnt_reg);
        OFS_RSTEN:  rdata_next = 32'(rsten_reg);
        OFS_LEVELS: rdata_next = 32'(rst_reg);
        default:    rdata_next = 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------------
  always_comb begin
    // the soft bit clears itself through the reset it causes; a write on
    // that same edge wins, so a request made during a reset is not lost
    soft_next  = soft_reg & ~rst_reg.sys;
    pinv_next  = pinv_reg;
    hsel_next  = hsel_reg;
    mask_next  = mask_reg;
    rsten_next = rsten_reg;
    if (wr_acc && avs_address_i == OFS_CTRL && avs_byteenable_i[0]) begin
      soft_next = avs_writedata_i[CTRL_SOFT_BIT];
      pinv_next = avs_writedata_i[CTRL_PINV_BIT];
      hsel_next = avs_writedata_i[CTRL_HSEL_BIT] ? HOST_SEL_ESPI
                                                 : HOST_SEL_LPC;
    end
    if (wr_acc && avs_address_i == OFS_MASK && avs_byteenable_i[0])
      mask_next = avs_writedata_i[ST_W-1:0];
    if (wr_acc && avs_address_i == OFS_RSTEN)
      rsten_next = NBLK'((32'(rsten_reg) & ~wmask) |
                         (avs_writedata_i & wmask));
    if (rst_reg.sys)
      rsten_next = '0;
    if (mpr) begin
      pinv_next = PINV_RST;
      hsel_next = HOST_SEL_LPC;
      mask_next = MASK_RST;
    end
  end

  // ---------------------------------------------------------------------
  // event status, watchdog counter and interrupt
  // ---------------------------------------------------------------------
  always_comb begin
    status_set          = '0;
    status_set[ST_WDT]  = watchdog_event_i;
    status_set[ST_EXT]  = ext_rst;
    status_set[ST_CORE] = core_reset_request_i;
    status_set[ST_SOFT] = soft_reg;
    // only bits that the read returned are cleared; a set wins
    status_next = status_reg | status_set;
    if (rd_acc && avs_address_i == OFS_STATUS)
      status_next = (status_reg & ~rdata_reg[ST_W-1:0]) | status_set;
    if (mpr)
      status_next = '0;
    irq_next = |(status_next & mask_next);
    wdt_cnt_next = wdt_cnt_reg;
    if (rst_reg.keep_wdt)
      wdt_cnt_next = '0;
    else if (watchdog_event_i)
      wdt_cnt_next = wdt_cnt_reg + 1'h1;
  end

  // ---------------------------------------------------------------------
  // reset derivation, all registered on clk_sys_i
  // ---------------------------------------------------------------------
  logic [HOLD_W-1:0] hold_reg, hold_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [NBLK-1:0]   slp_reg, slp_next;
  logic              mpr_prev_reg;
  logic              glitch_src, host_sel_rst;

  always_comb begin
    // watchdog is left out so its reset is not held by the filter
    glitch_src = mpr | ext_rst | soft_reg | core_reset_request_i;
    if (glitch_src)
      hold_next = HOLD_W'(GLITCH_CYCLES);
    else if (hold_reg != '0)
      hold_next = hold_reg - 1'h1;
    else
      hold_next = '0;
    rst_next          = '0;
    rst_next.sys      = glitch_src | watchdog_event_i |
                        (hold_reg != '0);
    rst_next.keep_wdt = mpr | ext_rst;
    rst_next.main_pwr = mpr;
    if (rst_next.sys)
      cnt_next = CNT_W'(STRETCH_CYCLES);
    else if (cnt_reg != '0)
      cnt_next = cnt_reg - 1'h1;
    else
      cnt_next = '0;
    rst_next.proc     = rst_next.sys | (cnt_reg != '0);
    rst_next.host_pwr = rst_reg.sys | ~pg_ok | pinv_reg;
    host_sel_rst = (hsel_reg == HOST_SEL_ESPI) ? ~espi_platform_reset_n_i
                                               : ~filt_reg[PIN_LPC];
    rst_next.host_if  = rst_next.host_pwr | host_sel_rst;
    rst_next.link     = ~filt_reg[PIN_LINK];
    rst_next.batt     = mpr_prev_reg & ~mpr & filt_reg[PIN_BATT];
    slp_next = sleep_request_i & rsten_reg & ~clock_request_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ack_reg      <= 1'h0;
      rdata_reg    <= 32'h0;
      soft_reg     <= 1'h0;
      pinv_reg     <= PINV_RST;
      hsel_reg     <= HOST_SEL_LPC;
      mask_reg     <= MASK_RST;
      rsten_reg    <= '0;
      status_reg   <= '0;
      wdt_cnt_reg  <= '0;
      irq_reg      <= 1'h0;
      hold_reg     <= '0;
      cnt_reg      <= CNT_W'(STRETCH_CYCLES);
      // battery reset stays low: it may only pulse on a power rise
      rst_reg      <= 8'h7F;
      slp_reg      <= '0;
      mpr_prev_reg <= 1'h1;
    end else begin
      ack_reg      <= ack_next;
      rdata_reg    <= rdata_next;
      soft_reg     <= soft_next;
      pinv_reg     <= pinv_next;
      hsel_reg     <= hsel_next;
      mask_reg     <= mask_next;
      rsten_reg    <= rsten_next;
      status_reg   <= status_next;
      wdt_cnt_reg  <= wdt_cnt_next;
      irq_reg      <= irq_next;
      hold_reg     <= hold_next;
      cnt_reg      <= cnt_next;
      rst_reg      <= rst_next;
      slp_reg      <= slp_next;
      mpr_prev_reg <= mpr;
    end
  end

  assign resets_o       = rst_reg;
  assign power_ok_o     = ~rst_reg.host_pwr;
  assign sleep_reset_o  = slp_reg;
  assign irq_o          = irq_reg;
  assign avs_readdata_o = rdata_reg;

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  sequence s_soft_write;
    wr_acc && avs_address_i == OFS_CTRL && avs_byteenable_i[0] &&
    avs_writedata_i[CTRL_SOFT_BIT];
  endsequence
  sequence s_soft_reset;
    ##1 soft_reg ##1 resets_o.sys;
  endsequence

  property p_sys_sources;
    (mpr || ext_rst || watchdog_event_i || core_reset_request_i)
      |=> resets_o.sys;
  endproperty
  a_sys_sources: assert property (p_sys_sources)
    else $error("system reset missed a source");

  property p_soft_reset;
    s_soft_write |-> s_soft_reset;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("software reset bit did not reset the system");

  property p_host_pwr;
    (resets_o.sys || !pg_ok || pinv_reg) |=> resets_o.host_pwr;
  endproperty
  a_host_pwr: assert property (p_host_pwr)
    else $error("host power reset not asserted");

  property p_power_ok;
    power_ok_o != resets_o.host_pwr;
  endproperty
  a_power_ok: assert property (p_power_ok)
    else $error("power ok is not the inverse of host power reset");

  property p_host_if;
    (hsel_reg == HOST_SEL_ESPI && !espi_platform_reset_n_i) ||
    (hsel_reg == HOST_SEL_LPC && !filt_reg[PIN_LPC])
      |=> resets_o.host_if;
  endproperty
  a_host_if: assert property (p_host_if)
    else $error("selected host reset did not reach host interface reset");

  property p_link;
    resets_o.link == !$past(filt_reg[PIN_LINK]);
  endproperty
  a_link: assert property (p_link)
    else $error("serial link reset does not follow its pin");

  property p_wdt_count;
    watchdog_event_i && !rst_reg.keep_wdt |=>
      wdt_cnt_reg == $past(wdt_cnt_reg) + 1'h1 && status_reg[ST_WDT];
  endproperty
  a_wdt_count: assert property (p_wdt_count)
    else $error("watchdog event not counted or not flagged");

  property p_wdt_no_hold;
    watchdog_event_i && !glitch_src && hold_reg == '0 |=> hold_reg == '0;
  endproperty
  a_wdt_no_hold: assert property (p_wdt_no_hold)
    else $error("watchdog reset started the glitch hold");

  property p_keep_wdt;
    resets_o.keep_wdt == $past(mpr || ext_rst);
  endproperty
  a_keep_wdt: assert property (p_keep_wdt)
    else $error("keep-watchdog reset has a wrong source");

  property p_stretch;
    $fell(resets_o.sys) |-> (cnt_reg == CNT_W'(STRETCH_CYCLES - 1))
      ##0 (resets_o.proc [*8]);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("processor reset not stretched after system reset");

  property p_stretch_end;
    cnt_reg == 1 && !rst_next.sys |=>
      resets_o.proc ##1 (!resets_o.proc || resets_o.sys);
  endproperty
  a_stretch_end: assert property (p_stretch_end)
    else $error("processor reset held past its stretch");

  property p_sleep;
    sleep_reset_o == $past(sleep_request_i & rsten_reg & ~clock_request_i);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("block sleep reset wrong");

  property p_batt;
    resets_o.batt |-> !$past(mpr) && $past(mpr, 2) ##1 !resets_o.batt;
  endproperty
  a_batt: assert property (p_batt)
    else $error("battery reset outside power rise or too long");
endmodule

// *** host_model.sv ***
// bench model of the host chipset and espi block driving host-side pins
// assumes the bench sets wanted levels; pins follow one edge later
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_sys_i,
  input  wire logic [3:0] want_i,
  output logic            power_good_o,
  output logic            lpc_reset_n_o,
  output logic            link_reset_n_o,
  output logic            platform_reset_n_o
);
  // ---------------------------------------------------------------------
  // pins move only just after a rising edge, as the real chipset would
  // ---------------------------------------------------------------------
  initial begin
    {platform_reset_n_o, link_reset_n_o, lpc_reset_n_o} = 3'h0;
    power_good_o = 1'b0;
  end
  always @(posedge clk_sys_i) begin
    {platform_reset_n_o, link_reset_n_o} <= want_i[3:2];
    {lpc_reset_n_o, power_good_o}        <= want_i[1:0];
  end
endmodule

// *** tb.sv ***
// self-checking bench for the reset signal generator
// assumes one 250 MHz clock and a short processor stretch parameter
`timescale 1ns/1ps
module tb;
  import reset_gen_pkg::*;
  localparam int NB  = 4;
  localparam int STR = 20;
  logic              clk_sys_i = 1'b0;
  logic              srst_i    = 1'b1;
  logic [ADDR_W-1:0] adr       = 5'h00;
  logic              rd        = 1'b0;
  logic              wr        = 1'b0;
  logic [31:0]       wd        = 32'h0;
  logic [31:0]       rdata;
  logic              wreq;
  logic              mpr       = 1'b1;
  logic              ext_n     = 1'b1;
  logic              wdt       = 1'b0;
  logic              core      = 1'b0;
  logic              batt_low  = 1'b0;
  logic [NB-1:0]     slp       = 4'h0;
  logic [NB-1:0]     creq      = 4'h0;
  logic [3:0]        want      = 4'hF;
  logic              pg, lpc_n, link_n, espi_n, pok, irq;
  reset_bus_t        rs;
  logic [NB-1:0]     blk_rst;
  int                n_fail    = 0;
  int                checks    = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  host_model PM (.clk_sys_i(clk_sys_i), .want_i(want),
    .power_good_o(pg), .lpc_reset_n_o(lpc_n),
    .link_reset_n_o(link_n), .platform_reset_n_o(espi_n));

  reset_signal_generator #(.NBLK(NB), .STRETCH_CYCLES(STR)) DUT (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .main_power_reset_i(mpr),
    .external_reset_pin_n_i(ext_n), .host_power_good_i(pg),
    .lpc_reset_n_i(lpc_n), .serial_link_reset_n_i(link_n),
    .battery_low_i(batt_low), .watchdog_event_i(wdt),
    .core_reset_request_i(core), .espi_platform_reset_n_i(espi_n),
    .sleep_request_i(slp), .clock_request_i(creq), .resets_o(rs),
    .power_ok_o(pok), .sleep_reset_o(blk_rst), .irq_o(irq));

  // ---------------------------------------------------------------------
  // expectations
  // ---------------------------------------------------------------------
  function automatic logic f_pwr(logic pg_v, logic inv);
    return !pg_v || inv;
  endfunction
  function automatic logic f_if(logic [3:0] w, logic inv, logic sel);
    return f_pwr(w[0], inv) || (sel ? !w[3] : !w[1]);
  endfunction

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // request held until the edge that samples waitrequest low
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge clk_sys_i);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys_i);
      if (wreq === 1'b0) break;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (i == 50) begin
      chk("bus wait", 0, 1);
      stop_test();
    end
  endtask
  task automatic wait_sys(logic v, int lim);
    int i;
    for (i = 0; i < lim && rs.sys !== v; i++) @(posedge clk_sys_i);
    if (i == lim) begin
      chk("sys wait", v, rs.sys);
      stop_test();
    end
  endtask

  initial begin
    cyc(50000);
    chk("run time", 0, 1);
    stop_test();
  end

  initial begin
    logic [31:0] q, r;
    logic [NB-1:0] en;
    int n, k;
    q = $urandom(82111);
    cyc(10);
    srst_i <= 1'b0;
    mpr <= 1'b0;
    wait_sys(0, 200);
    cyc(STR + 5);
    chk("power_ok", 1, pok);
    bus(0, OFS_CTRL, 0, q);
    chk("ctrl", 0, q & 32'h6);
    bus(0, OFS_WDTCNT, 0, q);
    chk("wdt count", 0, q);
    bus(1, 5'h18, 32'hFFFFFFFF, q);
    bus(0, 5'h18, 0, q);
    chk("unmapped", 0, q);
    $display("test reset done");

    bus(1, OFS_MASK, 32'h1, q);
    @(posedge clk_sys_i);
    wdt <= 1'b1;
    @(posedge clk_sys_i);
    wdt <= 1'b0;
    @(posedge clk_sys_i);
    chk("sys", 1, rs.sys);
    chk("keep_wdt", 0, rs.keep_wdt);
    chk("proc", 1, rs.proc);
    @(posedge clk_sys_i);
    chk("sys short", 0, rs.sys);
    n = 0;
    while (rs.proc === 1'b1 && n < 100) begin
      n++;
      @(posedge clk_sys_i);
    end
    chk("stretch", STR, n);
    chk("irq", 1, irq);
    bus(0, OFS_STATUS, 0, q);
    chk("status", 1, q[3:0]);
    bus(0, OFS_STATUS, 0, q);
    chk("status clear", 0, q[3:0]);
    cyc(2);
    chk("irq clear", 0, irq);
    bus(0, OFS_WDTCNT, 0, q);
    chk("wdt count", 1, q);
    bus(1, OFS_MASK, 0, q);
    $display("test watchdog done");

    @(posedge clk_sys_i);
    core <= 1'b1;
    @(posedge clk_sys_i);
    core <= 1'b0;
    cyc(20);
    chk("sys held", 1, rs.sys);
    wait_sys(0, 100);
    cyc(STR + 5);
    chk("irq masked", 0, irq);
    bus(0, OFS_STATUS, 0, q);
    chk("status core", 4, q[3:0]);
    bus(1, OFS_CTRL, 32'h1, q);
    wait_sys(1, 5);
    wait_sys(0, 100);
    cyc(STR + 5);
    bus(0, OFS_STATUS, 0, q);
    chk("status soft", 8, q[3:0]);
    @(posedge clk_sys_i);
    ext_n <= 1'b0;
    cyc(8);
    chk("sys pin", 1, rs.sys);
    chk("keep_wdt", 1, rs.keep_wdt);
    ext_n <= 1'b1;
    wait_sys(0, 100);
    cyc(STR + 5);
    bus(0, OFS_WDTCNT, 0, q);
    chk("wdt count", 0, q);
    bus(0, OFS_STATUS, 0, q);
    chk("status pin", 2, q[3:0]);
    $display("test sources done");

    for (k = 0; k < 12; k++) begin
      r = (k == 0) ? 32'h7A : $urandom;
      bus(1, OFS_CTRL, {29'h0, r[2:1], 1'b0}, q);
      want <= r[6:3];
      cyc(8);
      chk("host_pwr", f_pwr(r[3], r[1]), rs.host_pwr);
      chk("power_ok", !f_pwr(r[3], r[1]), pok);
      chk("host_if", f_if(r[6:3], r[1], r[2]), rs.host_if);
      chk("link", !r[5], rs.link);
    end
    want <= 4'hF;
    bus(1, OFS_CTRL, 0, q);
    $display("test host done");

    for (k = 0; k < 10; k++) begin
      r = (k == 0) ? 32'h0FF : $urandom;
      en = r[3:0];
      bus(1, OFS_RSTEN, {28'h0, en}, q);
      slp <= r[7:4];
      creq <= r[11:8];
      cyc(4);
      chk("sleep rst", en & r[7:4] & ~r[11:8], blk_rst);
    end
    slp <= 4'h0;
    $display("test sleep done");

    for (k = 0; k < 2; k++) begin
      bus(1, OFS_MASK, 32'hF, q);
      batt_low <= (k == 0);
      mpr <= 1'b1;
      n = 0;
      repeat (10) begin
        @(posedge clk_sys_i);
        n += int'(rs.batt);
      end
      chk("main_pwr", 1, rs.main_pwr);
      chk("keep_wdt", 1, rs.keep_wdt);
      mpr <= 1'b0;
      repeat (30) begin
        @(posedge clk_sys_i);
        n += int'(rs.batt);
      end
      chk("batt pulses", (k == 0), n);
      wait_sys(0, 100);
      cyc(STR + 5);
      bus(0, OFS_MASK, 0, q);
      chk("mask cleared", 0, q[3:0]);
    end
    $display("test power done");
    stop_test();
  end
endmodule
